// ==== hw/sfic_regs.sv ====
`timescale 1ns/1ps
`include "sfic_map.svh"

module sfic_regs (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // Avalon-MM slave
   input  wire logic [7:0]                    avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [31:0]                   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic [31:0]                        avs_readdata,
   output logic                               avs_waitrequest,
   // Accumulator file updates
   input  wire logic                          acc_wr_en,
   input  wire logic [`SFIC_ACC_PTR_W-1:0]    acc_wr_idx,
   input  wire logic [`SFIC_ACC_W-1:0]        acc_wr_data,
   input  wire logic [`SFIC_ACC_PTR_W-1:0]    accumulator_pointer,
   // Arithmetic results
   input  wire logic                          arith_done,
   input  wire logic                          arith_carry14,
   input  wire logic                          arith_carry15,
   input  wire logic                          addsub_done,
   input  wire logic                          addsub_carry,
   input  wire logic                          compare_instr,
   input  wire logic                          compare_equal,
   // Sequencer interrupt handshake
   input  wire logic                          irq_ack,
   input  wire logic                          return_from_interrupt_instr,
   input  wire logic                          pop_and_return_instr,
   output logic                               irq_request,
   // Locally enabled interrupt sources
   input  wire logic [`SFIC_IM_MOD_HI:0]      module_irq,
   input  wire logic                          system_irq,
   // Flag view for the datapath
   output logic [7:0]                         status_flags,
   // Event interrupt
   output logic                               evt_irq
);
   sfic_pkg::sfic_sel_t  sel;
   logic                 req;
   logic                 wr_fire;
   logic                 wr_lane0;
   logic [7:0]           wbyte;
   logic                 zero_flag;
   logic                 sign_flag;
   // Stored flag bits
   logic [1:0]           general_purpose_flags;
   logic                 overflow_flag;
   logic                 carry_flag;
   logic                 equal_flag;
   // Interrupt control
   logic                 interrupt_in_service;
   logic                 global_interrupt_enable;
   logic [7:0]           interrupt_module_mask;
   logic [`SFIC_EVT_W-1:0] evt_stat;
   logic [`SFIC_EVT_W-1:0] evt_mask;
   logic [`SFIC_EVT_W-1:0] evt_set;
   logic [7:0]           flags_view;
   logic [7:0]           mask_view;
   logic [7:0]           rd_byte;

   sfic_acc_mirror u_acc (
      .clk                 (clk),
      .rst                 (rst),
      .acc_wr_en           (acc_wr_en),
      .acc_wr_idx          (acc_wr_idx),
      .acc_wr_data         (acc_wr_data),
      .accumulator_pointer (accumulator_pointer),
      .zero_flag           (zero_flag),
      .sign_flag           (sign_flag)
   );

   // Address decode; low two bits must be zero for a hit
   always_comb begin
      sel = sfic_pkg::SFIC_SEL_NONE;
      if (avs_address[1:0] == 2'h0) begin
         unique case ({2'h0, avs_address[7:2]})
            `SFIC_IDX_FLAGS    : sel = sfic_pkg::SFIC_SEL_FLAGS;
            `SFIC_IDX_INT_CTRL : sel = sfic_pkg::SFIC_SEL_INT_CTRL;
            `SFIC_IDX_INT_MASK : sel = sfic_pkg::SFIC_SEL_INT_MASK;
            `SFIC_IDX_EVT_STAT : sel = sfic_pkg::SFIC_SEL_EVT_STAT;
            `SFIC_IDX_EVT_MASK : sel = sfic_pkg::SFIC_SEL_EVT_MASK;
            default            : sel = sfic_pkg::SFIC_SEL_NONE;
         endcase
      end
   end

   // A request completes on the edge where waitrequest is low
   assign req      = avs_read || avs_write;
   assign wr_fire  = avs_write && !avs_waitrequest;
   assign wr_lane0 = wr_fire && avs_byteenable[0];
   assign wbyte    = avs_writedata[7:0];

   // One wait cycle per access: drop waitrequest for exactly one edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else if (avs_waitrequest && req) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Assembled read views; reserved bits are constant zero
   always_comb begin
      flags_view = 8'h00;
      flags_view[`SFIC_FLG_ZERO]  = zero_flag;
      flags_view[`SFIC_FLG_SIGN]  = sign_flag;
      flags_view[`SFIC_FLG_GPF_HI:`SFIC_FLG_GPF_LO] = general_purpose_flags;
      flags_view[`SFIC_FLG_OVF]   = overflow_flag;
      flags_view[`SFIC_FLG_CARRY] = carry_flag;
      flags_view[`SFIC_FLG_EQUAL] = equal_flag;
      mask_view = interrupt_module_mask & 8'hbf;
   end

   always_comb begin
      rd_byte = 8'h00;
      unique case (sel)
         sfic_pkg::SFIC_SEL_FLAGS    : rd_byte = flags_view;
         sfic_pkg::SFIC_SEL_INT_CTRL : rd_byte = {6'h00, interrupt_in_service, global_interrupt_enable};
         sfic_pkg::SFIC_SEL_INT_MASK : rd_byte = mask_view;
         sfic_pkg::SFIC_SEL_EVT_STAT : rd_byte = {5'h00, evt_stat};
         sfic_pkg::SFIC_SEL_EVT_MASK : rd_byte = {5'h00, evt_mask};
         sfic_pkg::SFIC_SEL_NONE     : rd_byte = 8'h00;
      endcase
   end

   // Read data captured when waitrequest drops, stable at completion
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_waitrequest && avs_read) begin
         avs_readdata <= {24'h00_0000, rd_byte};
      end
   end

   // General purpose flags: software storage only, read back and also passed out on status_flags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         general_purpose_flags <= 2'h0;
      end else if (wr_lane0 && sel == sfic_pkg::SFIC_SEL_FLAGS) begin
         general_purpose_flags <= wbyte[`SFIC_FLG_GPF_HI:`SFIC_FLG_GPF_LO];
      end
   end

   // Overflow is hardware only; a software write leaves it alone
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         overflow_flag <= 1'b0;
      end else if (arith_done) begin
         overflow_flag <= arith_carry14 ^ arith_carry15;
      end
   end

   // Carry: datapath result wins over a software write in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         carry_flag <= 1'b0;
      end else if (addsub_done) begin
         carry_flag <= addsub_carry;
      end else if (wr_lane0 && sel == sfic_pkg::SFIC_SEL_FLAGS) begin
         carry_flag <= wbyte[`SFIC_FLG_CARRY];
      end
   end

   // Equals: compare result wins over a software write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         equal_flag <= 1'b0;
      end else if (compare_instr) begin
         equal_flag <= compare_equal;
      end else if (wr_lane0 && sel == sfic_pkg::SFIC_SEL_FLAGS) begin
         equal_flag <= wbyte[`SFIC_FLG_EQUAL];
      end
   end

   // Global enable is plain software state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         global_interrupt_enable <= 1'b0;
      end else if (wr_lane0 && sel == sfic_pkg::SFIC_SEL_INT_CTRL) begin
         global_interrupt_enable <= wbyte[`SFIC_IC_IGE];
      end
   end

   // In-service: acknowledge sets and beats any clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         interrupt_in_service <= 1'b0;
      end else if (irq_ack) begin
         interrupt_in_service <= 1'b1;
      end else if (return_from_interrupt_instr || pop_and_return_instr) begin
         interrupt_in_service <= 1'b0;
      end else if (wr_lane0 && sel == sfic_pkg::SFIC_SEL_INT_CTRL) begin
         interrupt_in_service <= wbyte[`SFIC_IC_INS];
      end
   end

   // Module mask; reserved bit 6 is never stored
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         interrupt_module_mask <= `SFIC_RST_INT_MASK;
      end else if (wr_lane0 && sel == sfic_pkg::SFIC_SEL_INT_MASK) begin
         interrupt_module_mask <= wbyte & 8'hbf;
      end
   end

   // Request to sequencer; priority is left to software masking
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_request <= 1'b0;
      end else begin
         irq_request <= global_interrupt_enable
                        && !interrupt_in_service && !irq_ack
                        && ((|(module_irq & interrupt_module_mask[`SFIC_IM_MOD_HI:0]))
                            || (system_irq && interrupt_module_mask[`SFIC_IM_SYS]));
      end
   end

   // Flag byte for the datapath, same layout as the register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_flags <= `SFIC_RST_FLAGS;
      end else begin
         status_flags <= flags_view;
      end
   end

   // Events worth telling software about
   always_comb begin
      evt_set = '0;
      evt_set[`SFIC_EVT_ACK]   = irq_ack;
      evt_set[`SFIC_EVT_OVF]   = arith_done && (arith_carry14 ^ arith_carry15);
      evt_set[`SFIC_EVT_EQUAL] = compare_instr && compare_equal;
   end

   // Sticky status, write one to clear; a new event wins the clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         evt_stat <= '0;
      end else if (wr_lane0 && sel == sfic_pkg::SFIC_SEL_EVT_STAT) begin
         evt_stat <= (evt_stat & ~wbyte[`SFIC_EVT_W-1:0]) | evt_set;
      end else begin
         evt_stat <= evt_stat | evt_set;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         evt_mask <= '0;
      end else if (wr_lane0 && sel == sfic_pkg::SFIC_SEL_EVT_MASK) begin
         evt_mask <= wbyte[`SFIC_EVT_W-1:0];
      end
   end

   // Level interrupt, one cycle behind the sticky bits
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         evt_irq <= 1'b0;
      end else begin
         evt_irq <= |(evt_stat & evt_mask);
      end
   end
endmodule : sfic_regs

// ==== hw/sfic_map.svh ====
`ifndef SFIC_MAP_SVH
`define SFIC_MAP_SVH

// Register indices; byte address is four times the index
`define SFIC_IDX_FLAGS      8'h04
`define SFIC_IDX_INT_CTRL   8'h05
`define SFIC_IDX_INT_MASK   8'h06
`define SFIC_IDX_EVT_STAT   8'h10
`define SFIC_IDX_EVT_MASK   8'h11

// Reset values
`define SFIC_RST_FLAGS      8'h80
`define SFIC_RST_INT_CTRL   8'h00
`define SFIC_RST_INT_MASK   8'h00
`define SFIC_RST_EVT        8'h00

// Status flag fields
`define SFIC_FLG_ZERO       7
`define SFIC_FLG_SIGN       6
`define SFIC_FLG_GPF_HI     4
`define SFIC_FLG_GPF_LO     3
`define SFIC_FLG_OVF        2
`define SFIC_FLG_CARRY      1
`define SFIC_FLG_EQUAL      0

// Interrupt control fields
`define SFIC_IC_INS         1
`define SFIC_IC_IGE         0

// Interrupt mask fields
`define SFIC_IM_SYS         7
`define SFIC_IM_MOD_HI      5

// Event status fields
`define SFIC_EVT_ACK        0
`define SFIC_EVT_OVF        1
`define SFIC_EVT_EQUAL      2
`define SFIC_EVT_W          3

// Accumulator bank geometry
`define SFIC_ACC_W          16
`define SFIC_ACC_N          16
`define SFIC_ACC_PTR_W      4

`endif

// ==== hw/sfic_pkg.sv ====
package sfic_pkg;
   // Register selected by the bus decoder
   typedef enum logic [2:0] {
      SFIC_SEL_NONE,
      SFIC_SEL_FLAGS,
      SFIC_SEL_INT_CTRL,
      SFIC_SEL_INT_MASK,
      SFIC_SEL_EVT_STAT,
      SFIC_SEL_EVT_MASK
   } sfic_sel_t;

   typedef logic [7:0] sfic_byte_t;
endpackage : sfic_pkg

// ==== hw/sfic_acc_mirror.sv ====
`timescale 1ns/1ps
`include "sfic_map.svh"

module sfic_acc_mirror (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // Accumulator writes from datapath
   input  wire logic                          acc_wr_en,
   input  wire logic [`SFIC_ACC_PTR_W-1:0]    acc_wr_idx,
   input  wire logic [`SFIC_ACC_W-1:0]        acc_wr_data,
   // Active accumulator select
   input  wire logic [`SFIC_ACC_PTR_W-1:0]    accumulator_pointer,
   // Derived flags
   output logic                               zero_flag,
   output logic                               sign_flag
);
   logic [`SFIC_ACC_W-1:0] acc_mem [`SFIC_ACC_N];
   logic [`SFIC_ACC_W-1:0] next_active;

   // Mirror of the accumulator file, cleared with the core
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `SFIC_ACC_N; i++) begin
            acc_mem[i] <= 16'h0000;
         end
      end else if (acc_wr_en) begin
         acc_mem[acc_wr_idx] <= acc_wr_data;
      end
   end

   // Forward a same-cycle write so flags never lag the datapath
   always_comb begin
      if (acc_wr_en && (acc_wr_idx == accumulator_pointer)) begin
         next_active = acc_wr_data;
      end else begin
         next_active = acc_mem[accumulator_pointer];
      end
   end

   // Flags follow the active accumulator one cycle later
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         zero_flag <= 1'b1;
         sign_flag <= 1'b0;
      end else begin
         zero_flag <= (next_active == 16'h0000);
         sign_flag <= next_active[`SFIC_ACC_W-1];
      end
   end
endmodule : sfic_acc_mirror

// ==== testbench/sfic_regs_assertions.sv ====
`timescale 1ns/1ps
`include "sfic_map.svh"
module sfic_regs_chk (
   // Clock, reset, bus
   input wire logic                       clk,
   input wire logic                       rst,
   input wire logic                       avs_read,
   input wire logic                       avs_write,
   input wire logic [31:0]                avs_readdata,
   input wire logic                       avs_waitrequest,
   // Datapath
   input wire logic                       acc_wr_en,
   input wire logic [`SFIC_ACC_PTR_W-1:0] acc_wr_idx,
   input wire logic [`SFIC_ACC_W-1:0]     acc_wr_data,
   input wire logic [`SFIC_ACC_PTR_W-1:0] accumulator_pointer,
   input wire logic                       arith_done,
   input wire logic                       arith_carry14,
   input wire logic                       arith_carry15,
   input wire logic                       addsub_done,
   input wire logic                       addsub_carry,
   input wire logic                       compare_instr,
   input wire logic                       compare_equal,
   // Interrupts and flags
   input wire logic                       irq_ack,
   input wire logic                       irq_request,
   input wire logic [`SFIC_IM_MOD_HI:0]   module_irq,
   input wire logic                       system_irq,
   input wire logic [7:0]                 status_flags
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Reset must be checked while reset is high
   flags_reset_a: assert property (disable iff (1'b0) rst |-> status_flags == 8'h80 && !irq_request)
      else $error("flags reset value");
   rsvd_read_a: assert property (avs_readdata[31:8] == 24'h0)
      else $error("readdata upper bits");
   bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest timing");
   sign_track_a: assert property (acc_wr_en && acc_wr_idx == accumulator_pointer |->
      ##2 status_flags[6] == $past(acc_wr_data[15], 2)) else $error("sign flag");
   ovf_flag_a: assert property (arith_done |-> ##2 status_flags[2] == $past(arith_carry14 ^ arith_carry15, 2))
      else $error("overflow flag");
   carry_flag_a: assert property (addsub_done |-> ##2 status_flags[1] == $past(addsub_carry, 2))
      else $error("carry flag");
   equal_flag_a: assert property (compare_instr |-> ##2 status_flags[0] == $past(compare_equal, 2))
      else $error("equals flag");
   ack_block_a: assert property (irq_ack |=> !irq_request [*2])
      else $error("request after ack");
   req_cause_a: assert property (irq_request |-> $past(module_irq != 6'h0 || system_irq) && !$past(irq_ack))
      else $error("request without source");
endmodule : sfic_regs_chk
bind sfic_regs sfic_regs_chk u_chk (.*);

// ==== testbench/sfic_core_model.sv ====
`timescale 1ns/1ps
module sfic_core_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Sequencer handshake
   input  wire logic irq_request,
   input  wire logic ack_en,
   input  wire logic slow,
   output logic      irq_ack
);
   logic [1:0] dly;
   // One ack pulse per request, at once or after three cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_ack <= 1'b0;
         dly     <= 2'h0;
      end else begin
         irq_ack <= 1'b0;
         dly     <= 2'h0;
         if (irq_request && ack_en && !irq_ack) begin
            irq_ack <= !slow || dly == 2'h3;
            dly     <= dly + 2'h1;
         end
      end
   end
endmodule : sfic_core_model

// ==== testbench/tb_status_flags_interrupt_ctrl.sv ====
`timescale 1ns/1ps
module tb_status_flags_interrupt_ctrl;
   logic        clk, rst, avs_read, avs_write, acc_wr_en, arith_done, arith_carry14, arith_carry15;
   logic        addsub_done, addsub_carry, compare_instr, compare_equal, return_from_interrupt_instr;
   logic        pop_and_return_instr, system_irq, irq_ack, irq_request, evt_irq, avs_waitrequest, ack_en, slow;
   logic [7:0]  avs_address, status_flags, rd;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable, acc_wr_idx, accumulator_pointer;
   logic [15:0] acc_wr_data;
   logic [5:0]  module_irq;
   int          n_fail = 0, tests_run = 0;
   typedef struct {logic [7:0] a, d, e;} sfic_row_t;
   // Address, written value, value read back
   sfic_row_t   rows [8] = '{'{8'h10, 8'hff, 8'h9b}, '{8'h10, 8'h00, 8'h80}, '{8'h14, 8'hff, 8'h03},
      '{8'h14, 8'h00, 8'h00}, '{8'h18, 8'hff, 8'hbf}, '{8'h18, 8'h00, 8'h00}, '{8'h3c, 8'hff, 8'h00},
      '{8'h11, 8'hff, 8'h00}};
   sfic_regs dut (.*);
   sfic_core_model u_core (.*);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic final_report();
      if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 30);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         n_fail++;
         final_report();
      end
      @(posedge clk);
   endtask : bus
   task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      check(nm, rd, e);
   endtask : rdc
   task automatic wt();
      repeat (3) @(posedge clk);
   endtask : wt
   task automatic acc(input logic [3:0] i, input logic [15:0] d);
      acc_wr_en <= 1'b1;
      acc_wr_idx <= i;
      acc_wr_data <= d;
      @(posedge clk);
      acc_wr_en <= 1'b0;
      wt();
   endtask : acc
   task automatic op(input logic c14, input logic c15, input logic cy, input logic eq);
      {arith_done, addsub_done, compare_instr} <= 3'h7;
      {arith_carry14, arith_carry15, addsub_carry, compare_equal} <= {c14, c15, cy, eq};
      @(posedge clk);
      {arith_done, addsub_done, compare_instr} <= 3'h0;
      wt();
   endtask : op
   // Main sequence
   initial begin
      {avs_read, avs_write, acc_wr_en, arith_done, arith_carry14, arith_carry15, addsub_done} = '0;
      {addsub_carry, compare_instr, compare_equal, return_from_interrupt_instr, pop_and_return_instr} = '0;
      {system_irq, ack_en, slow, avs_address, avs_writedata, acc_wr_idx, acc_wr_data} = '0;
      {accumulator_pointer, module_irq} = '0;
      avs_byteenable = 4'hf;
      // Scheduled so the async reset edge is seen before the first clock
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].d);
         rdc("reg", rows[i].a, rows[i].e);
      end
      avs_byteenable <= 4'he;
      bus(1'b1, 8'h14, 8'h01);
      avs_byteenable <= 4'hf;
      rdc("ctrl_be", 8'h14, 8'h00);
      // Reset in mid-run after dirtying registers
      bus(1'b1, 8'h10, 8'h1b);
      bus(1'b1, 8'h18, 8'hff);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdc("flags_rst", 8'h10, 8'h80);
      rdc("ctrl_rst", 8'h14, 8'h00);
      rdc("mask_rst", 8'h18, 8'h00);
      // Zero and sign follow the selected accumulator
      accumulator_pointer <= 4'h3;
      acc(4'h3, 16'h8000);
      rdc("zs_neg", 8'h10, 8'h40);
      accumulator_pointer <= 4'h5;
      wt();
      rdc("zs_zero", 8'h10, 8'h80);
      acc(4'h5, 16'h0001);
      rdc("zs_pos", 8'h10, 8'h00);
      op(1'b1, 1'b0, 1'b1, 1'b1);
      rdc("arith1", 8'h10, 8'h07);
      op(1'b1, 1'b1, 1'b0, 1'b0);
      rdc("arith2", 8'h10, 8'h00);
      op(1'b0, 1'b1, 1'b0, 1'b1);
      rdc("arith3", 8'h10, 8'h05);
      // Event interrupt: clear, mask, raise
      rdc("evt_set", 8'h40, 8'h06);
      bus(1'b1, 8'h40, 8'h07);
      rdc("evt_clr", 8'h40, 8'h00);
      bus(1'b1, 8'h44, 8'h04);
      rdc("evt_msk", 8'h44, 8'h04);
      op(1'b0, 1'b0, 1'b0, 1'b1);
      check("evt_on", evt_irq, 8'h01);
      bus(1'b1, 8'h44, 8'h00);
      wt();
      check("evt_mask", evt_irq, 8'h00);
      bus(1'b1, 8'h40, 8'h04);
      rdc("evt_clr2", 8'h40, 8'h00);
      // Module masks, global enable, system group
      bus(1'b1, 8'h14, 8'h01);
      for (int k = 0; k < 6; k++) begin
         bus(1'b1, 8'h18, 8'h01 << k);
         module_irq <= 6'h01 << k;
         wt();
         check("irq_on", irq_request, 8'h01);
         module_irq <= 6'h01 << ((k + 1) % 6);
         wt();
         check("irq_off", irq_request, 8'h00);
      end
      bus(1'b1, 8'h14, 8'h00);
      bus(1'b1, 8'h18, 8'h81);
      wt();
      check("irq_ige", irq_request, 8'h00);
      module_irq <= 6'h00;
      system_irq <= 1'b1;
      bus(1'b1, 8'h14, 8'h01);
      wt();
      check("irq_sys", irq_request, 8'h01);
      bus(1'b1, 8'h18, 8'h01);
      wt();
      check("irq_sysm", irq_request, 8'h00);
      bus(1'b1, 8'h18, 8'h80);
      // Ack sets in-service; three ways of clearing it
      for (int k = 0; k < 3; k++) begin
         slow <= k[0];
         ack_en <= 1'b1;
         repeat (8) @(posedge clk);
         ack_en <= 1'b0;
         check("irq_ack", irq_request, 8'h00);
         rdc("ins_set", 8'h14, 8'h03);
         if (k == 0) bus(1'b1, 8'h14, 8'h01);
         return_from_interrupt_instr <= k == 1;
         pop_and_return_instr <= k == 2;
         @(posedge clk);
         {return_from_interrupt_instr, pop_and_return_instr} <= 2'h0;
         wt();
         check("irq_nest", irq_request, 8'h01);
         rdc("ins_clr", 8'h14, 8'h01);
      end
      // Only the acknowledges have left a sticky event behind
      rdc("evt_ack", 8'h40, 8'h01);
      final_report();
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report();
   end
endmodule : tb_status_flags_interrupt_ctrl
